// ---- scr_pkg.sv ----
// Constants and register defaults for the serial configuration register port.
package scr_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int SCR_FRAME_BITS = 24;
  localparam int SCR_DATA_BITS = 16;
  localparam logic [4:0] SCR_CNT_HDR_LAST = 5'h07;
  localparam logic [4:0] SCR_CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] SCR_CNT_LAST = 5'h17;
  localparam logic SCR_RW_WRITE = 1'b0;
  localparam logic SCR_RW_READ = 1'b1;

  // ---------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------
  localparam int SCR_NUM_REGS = 126;
  localparam logic [6:0] SCR_LAST_ADDR = 7'h7d;
  localparam int SCR_R0_RESET_BIT = 1;
  localparam int SCR_R0_FCAL_BIT = 3;
  localparam int SCR_R0_LDSEL_BIT = 2;
  localparam int SCR_NUM_DBUF = 4;
  localparam logic [6:0] SCR_DBUF_ADDR [SCR_NUM_DBUF] = '{7'h22, 7'h24, 7'h26, 7'h2a};
  localparam logic [15:0] SCR_DBUF_RESET = 16'h0000;
  localparam logic SCR_SYNC_RESET = 1'b0;
  localparam logic SCR_CS_SYNC_RESET = 1'b1;

  // Power-on value of each register; registers not listed come up as zero.
  function automatic logic [15:0] scr_default(input logic [6:0] addr);
    case (addr)
      7'h00: scr_default = 16'h221c;
      7'h01: scr_default = 16'h0808;
      7'h02: scr_default = 16'h0500;
      7'h03: scr_default = 16'h0782;
      7'h04: scr_default = 16'h0a43;
      7'h05: scr_default = 16'h30c8;
      7'h06: scr_default = 16'hc802;
      7'h07: scr_default = 16'h00b2;
      7'h08: scr_default = 16'h2000;
      7'h09: scr_default = 16'h0004;
      7'h0a: scr_default = 16'h10f8;
      default: scr_default = 16'h0000;
    endcase
  endfunction : scr_default

endpackage : scr_pkg

// ---- scr_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module scr_pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);

  logic s1;
  logic s2;
  logic s3;

  // The first stage feeds only the second; the output moves only when stages two and three agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

endmodule : scr_pin_sync

// ---- scr_serial_port.sv ----
// Three-wire serial configuration port with 126-word register bank.
//
// Contract
// RULE1: Frame is 24 bits: flag, seven address bits, sixteen data bits.
// RULE2: Flag zero means write, flag one means read.
// RULE3: Frames travel most significant bit first into the shift register.
// RULE4: Serial input is sampled on each serial clock rise while selected.
// RULE5: Write data lands in the addressed register at the 24th rising edge.
// RULE6: With select high, clock pulses are ignored and state holds.
// RULE7: During a read, serial input in the data field is ignored.
// RULE8: Read data leaves MSB first on falling edges from the eighth clock.
// RULE9: Host raises chip enable and waits 500 us before programming; the host model has no chip enable and waits 20 clock cycles after reset.
// RULE10: Host supplies a valid reference clock before initialization writes.
// RULE11: Writing reset bit of register zero restores defaults; bit self-clears.
// RULE12: Host initializes registers 125 down to 1, then register 0.
// RULE13: Bank holds 126 sixteen-bit registers at addresses 0 to 125.
// RULE14: Host may skip registers whose wanted value equals the default.
// RULE15: Every register can be read back through a read frame.
// RULE16: Block mode: later 16-bit words go to the next lower address.
// RULE17: Double-buffered fields apply only on register zero write with calibration enable.
// RULE18: Select high clears the bit counter and drops any partial frame.
`timescale 1ns/1ps
module scr_serial_port (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Serial link
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_DATA_IN,
  output logic MULTIPLEXED_READBACK_OUT,
  // Configuration outputs
  output logic [15:0] CFG_R0,
  output logic [scr_pkg::SCR_NUM_DBUF*scr_pkg::SCR_DATA_BITS-1:0] APPLIED_CFG,
  output logic CAL_START
);
  import scr_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ---------------------------------------------------------------
  logic cs_n_f;
  logic sck_f;
  logic sdi_f;
  logic sck_d;

  scr_pin_sync #(.RESET_VAL(SCR_CS_SYNC_RESET)) u_cs_sync (
    .clk(SYS_CLK), .rst_n(RST_N), .pin(CHIP_SELECT_N), .level(cs_n_f)
  );
  scr_pin_sync #(.RESET_VAL(SCR_SYNC_RESET)) u_sck_sync (
    .clk(SYS_CLK), .rst_n(RST_N), .pin(SERIAL_CLK), .level(sck_f)
  );
  // Data takes the same three-stage path as the clock, so it stays aligned with its edge.
  scr_pin_sync #(.RESET_VAL(SCR_SYNC_RESET)) u_sdi_sync (
    .clk(SYS_CLK), .rst_n(RST_N), .pin(SERIAL_DATA_IN), .level(sdi_f)
  );

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_d <= SCR_SYNC_RESET;
    end else begin
      sck_d <= sck_f;
    end
  end

  logic cs_act;
  logic sck_rise;
  logic sck_fall;
  assign cs_act = !cs_n_f;
  assign sck_rise = cs_act && sck_f && !sck_d; // RULE4 RULE6
  assign sck_fall = cs_act && !sck_f && sck_d;

  // ---------------------------------------------------------------
  // Frame reception
  // ---------------------------------------------------------------
  logic [4:0] bit_cnt;
  logic [22:0] shifter;
  logic [6:0] addr;
  logic rw;
  logic word_end;
  logic [15:0] word_data;
  logic addr_ok;

  assign word_end = sck_rise && (bit_cnt == SCR_CNT_LAST);
  assign word_data = {shifter[14:0], sdi_f};
  assign addr_ok = (addr <= SCR_LAST_ADDR); // RULE13

  // Bit counter; a block frame loops back to the first data bit.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_cnt <= 5'h00;
    end else if (!cs_act) begin
      bit_cnt <= 5'h00; // RULE18
    end else if (word_end) begin
      bit_cnt <= SCR_CNT_DATA_FIRST; // RULE1 RULE16
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      shifter <= '0;
    end else if (sck_rise) begin
      shifter <= {shifter[21:0], sdi_f}; // RULE3 RULE4
    end
  end

  // Header capture and address step-down for block mode.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rw <= SCR_RW_WRITE;
      addr <= 7'h00;
    end else if (sck_rise && bit_cnt == SCR_CNT_HDR_LAST) begin
      rw <= shifter[6]; // RULE2
      addr <= {shifter[5:0], sdi_f};
    end else if (word_end) begin
      addr <= addr - 7'h01; // RULE16
    end
  end

  // ---------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------
  logic [15:0] cfg [SCR_NUM_REGS];
  logic do_write;
  logic do_reset;
  logic do_fcal;

  assign do_write = word_end && (rw == SCR_RW_WRITE) && addr_ok; // RULE2 RULE5 RULE7
  assign do_reset = do_write && addr == 7'h00 && word_data[SCR_R0_RESET_BIT];
  assign do_fcal = do_write && addr == 7'h00 && !word_data[SCR_R0_RESET_BIT]
    && word_data[SCR_R0_FCAL_BIT];

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < SCR_NUM_REGS; i++) begin
        cfg[i] <= scr_default(7'(i));
      end
    end else if (do_reset) begin
      // Restoring register zero's default also leaves the reset bit cleared.
      for (int i = 0; i < SCR_NUM_REGS; i++) begin
        cfg[i] <= scr_default(7'(i)); // RULE11
      end
    end else if (do_write) begin
      cfg[addr] <= word_data; // RULE5
    end
  end

  // Double-buffered copies follow the bank only on a calibration-enabled write of register zero.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      APPLIED_CFG <= {SCR_NUM_DBUF{SCR_DBUF_RESET}};
      CAL_START <= 1'b0;
    end else begin
      CAL_START <= do_fcal; // RULE17
      if (do_fcal) begin
        for (int i = 0; i < SCR_NUM_DBUF; i++) begin
          APPLIED_CFG[i*SCR_DATA_BITS +: SCR_DATA_BITS] <= cfg[SCR_DBUF_ADDR[i]]; // RULE17
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CFG_R0 <= scr_default(7'h00);
    end else begin
      CFG_R0 <= cfg[0];
    end
  end

  // ---------------------------------------------------------------
  // Readback
  // ---------------------------------------------------------------
  logic [3:0] rd_idx;
  logic rd_bit;
  assign rd_idx = 4'(SCR_CNT_LAST - bit_cnt);
  assign rd_bit = addr_ok ? cfg[addr][rd_idx] : 1'b0; // RULE15

  // The pin is low whenever no read data is being shifted out.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MULTIPLEXED_READBACK_OUT <= 1'b0;
    end else if (!cs_act) begin
      MULTIPLEXED_READBACK_OUT <= 1'b0;
    end else if (sck_fall && bit_cnt >= SCR_CNT_DATA_FIRST) begin
      MULTIPLEXED_READBACK_OUT <= (rw == SCR_RW_READ) ? rd_bit : 1'b0; // RULE8
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  cnt_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE18
    !cs_act |=> bit_cnt == 5'h00)
    else $error("bit counter not cleared while deselected");

  cnt_range_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE1
    bit_cnt <= SCR_CNT_LAST)
    else $error("bit counter beyond frame length");

  shift_in_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE3
    sck_rise |=> shifter[0] == $past(sdi_f) && shifter[22:1] == $past(shifter[21:0]))
    else $error("serial bit not shifted in msb first");

  idle_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE6
    !cs_act |=> $stable(shifter) && $stable(cfg[0]) && $stable(addr))
    else $error("state changed while deselected");

  write_land_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE5
    do_write && !do_reset |=> cfg[$past(addr)] == $past(word_data))
    else $error("write data not stored at frame end");

  read_keep_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE7
    word_end && rw == SCR_RW_READ |=> $stable(cfg[0]) && $stable(cfg[1]))
    else $error("read frame altered a register");

  reset_bit_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE11
    do_reset |=> cfg[0] == scr_default(7'h00) && !cfg[0][SCR_R0_RESET_BIT]
      && cfg[10] == scr_default(7'h0a))
    else $error("reset bit did not restore defaults");

  read_out_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE8
    sck_fall && rw == SCR_RW_READ && bit_cnt >= SCR_CNT_DATA_FIRST
      |=> MULTIPLEXED_READBACK_OUT == $past(rd_bit))
    else $error("readback bit wrong after falling edge");

  block_step_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE16
    word_end |=> addr == $past(addr) - 7'h01 && bit_cnt == SCR_CNT_DATA_FIRST)
    else $error("block mode did not step address down");

  fcal_apply_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE17
    !do_fcal |=> $stable(APPLIED_CFG))
    else $error("double-buffered value applied without calibration write");

endmodule : scr_serial_port

// ---- scr_host.sv ----
// Serial host model that drives frames onto the configuration link.
`timescale 1ns/1ps
module scr_host #(
  parameter int PWRUP_CYC = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link
  output logic cs_n,
  output logic sck,
  output logic serial_data_in,
  input wire logic readback
);
  int up_cnt = 0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    serial_data_in = 1'b0;
  end
  // Stand-in for the supply settling wait, shortened to keep the run brief.
  always @(posedge clk) up_cnt <= rst_n ? up_cnt + 1 : 0;
  task automatic bit_x(input logic b, output logic r);
    @(posedge clk);
    sck <= 1'b0;
    serial_data_in <= b;
    repeat (4) @(posedge clk);
    sck <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    r = readback;
  endtask : bit_x
  task automatic start();
    // The system clock stands in for the reference and runs from time zero.
    while (up_cnt < PWRUP_CYC) @(posedge clk);
    @(posedge clk);
    cs_n <= 1'b0;
  endtask : start
  task automatic hdr(input logic rw, input logic [6:0] a);
    logic r;
    logic [7:0] h;
    h = {rw, a};
    for (int i = 7; i >= 0; i--) bit_x(h[i], r);
  endtask : hdr
  task automatic word(input logic [15:0] v, output logic [15:0] rd);
    for (int i = 15; i >= 0; i--) bit_x(v[i], rd[i]);
  endtask : word
  // Released data shows the inverse of its last value, not a stale copy.
  task automatic stop();
    @(posedge clk);
    sck <= 1'b0;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    serial_data_in <= ~serial_data_in;
    repeat (6) @(posedge clk);
  endtask : stop
  task automatic stray(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      sck <= ~sck;
      serial_data_in <= ~serial_data_in;
    end
  endtask : stray
endmodule : scr_host

// ---- tb_top.sv ----
// Self-checking bench for the serial configuration register port.
`timescale 1ns/1ps
module tb_top;
  import scr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sck, serial_data_in, rb, cal;
  logic [15:0] r0, rd;
  logic [SCR_NUM_DBUF*SCR_DATA_BITS-1:0] app;
  int failures = 0;
  int num_checks = 0;
  int cals = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (cal === 1'b1) cals <= cals + 1;
  scr_serial_port scr_serial_port_i (.SYS_CLK(clk), .RST_N(rst_n), .CHIP_SELECT_N(cs_n),
    .SERIAL_CLK(sck), .SERIAL_DATA_IN(serial_data_in), .MULTIPLEXED_READBACK_OUT(rb),
    .CFG_R0(r0), .APPLIED_CFG(app), .CAL_START(cal));
  scr_host scr_host_i (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .serial_data_in(serial_data_in),
    .readback(rb));
  function automatic logic [15:0] val(input logic [6:0] a);
    val = {a, ~a, 2'b01};
  endfunction : val
  task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    scr_host_i.start();
    scr_host_i.hdr(1'b0, a);
    scr_host_i.word(d, rd);
    scr_host_i.stop();
  endtask : wr
  // The data field carries all ones during reads, which must be ignored.
  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    scr_host_i.start();
    scr_host_i.hdr(1'b1, a);
    scr_host_i.word(16'hffff, rd);
    scr_host_i.stop();
    check("readback", e, rd);
  endtask : rdchk
  task automatic t_reset();
    check("cfg_r0", 16'h221c, r0);
    check("applied", '0, app);
    check("idle out", 1'b0, rb);
    $display("test reset done");
  endtask : t_reset
  task automatic t_rw();
    wr(7'h05, 16'h1234);
    rdchk(7'h05, 16'h1234);
    rdchk(7'h05, 16'h1234);
    wr(7'h7d, 16'hbeef);
    rdchk(7'h7d, 16'hbeef);
    wr(7'h7e, 16'h5555);
    rdchk(7'h7e, 16'h0000);
    $display("test write read done");
  endtask : t_rw
  task automatic t_abort();
    scr_host_i.start();
    scr_host_i.hdr(1'b0, 7'h05);
    scr_host_i.stop();
    scr_host_i.stray(16);
    rdchk(7'h05, 16'h1234);
    $display("test abort done");
  endtask : t_abort
  task automatic t_init();
    int c;
    c = cals;
    wr(7'h00, 16'h221e);
    check("cfg_r0", 16'h221c, r0);
    check("cal count", c, cals);
    // The reset write above restored register 5's default, replacing the 16'h1234 written earlier.
    rdchk(7'h05, 16'h30c8);
    scr_host_i.start();
    scr_host_i.hdr(1'b0, 7'h7d);
    for (int a = 125; a >= 1; a--) scr_host_i.word(val(7'(a)), rd);
    scr_host_i.stop();
    check("applied", '0, app);
    wr(7'h00, 16'h221c);
    check("cal count", c + 1, cals);
    check("applied", {val(7'h2a), val(7'h26), val(7'h24), val(7'h22)}, app);
    scr_host_i.start();
    scr_host_i.hdr(1'b1, 7'h7d);
    for (int a = 125; a >= 123; a--) begin
      scr_host_i.word(16'h0000, rd);
      check("block read", val(7'(a)), rd);
    end
    scr_host_i.stop();
    $display("test init done");
  endtask : t_init
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_rw();
    t_abort();
    t_init();
    complete_run();
  end
endmodule : tb_top
